// ==== src/rgc_gpio_window.v ====
// Purpose: Pin 4.5-4.7 control, monitor index/data pair, reserved range, event bits
// Assumes: Single 25 MHz clock, synchronous active-high reset, byte register port
// Notes: Monitor registers sit outside; this block forwards index and data strobes
//
// Contract
// RULE_01 - Bit 0: one is input, zero output
// RULE_02 - Bit 1: one inverts pin value
// RULE_03 - Six-port: bit2 set gives serial six
// RULE_04 - Reset variant: bit2 clear gives PCI resets
// RULE_05 - Bit 7: one open-drain, zero push-pull
// RULE_06 - Bits 6:3 reserved, no function
// RULE_07 - Index at 70 selects monitor register
// RULE_08 - Data at 71 accesses indexed register
// RULE_09 - Offsets 74-7F read as zero
// RULE_10 - Software programs all bits for alternates
// RULE_11 - Edge event: both edges set status
// RULE_12 - Density function: floppy bits override type
// RULE_13 - SMI inactive without group or enable
// RULE_14 - Inactive SMI floats or drives high
// RULE_15 - Main POR may set wake status bit3
// RULE_16 - Those bits stored, no circuit effect
// RULE_17 - Software picks ring wake enable
// RULE_18 - Software sets port-1 bit7 pin push-pull
// RULE_19 - Index persists until rewritten
`include "rgc_map.vh"
module rgc_gpio_window #(
  parameter SIX_PORT = 0, // 1 selects the six-port variant
  parameter NPIN = 3 // Pins 4.5, 4.6, 4.7
) (
  // Clock and reset
  input wire core_clk_i,
  input wire srst_i,
  // Register port
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  // Hardware monitor side
  output wire [7:0] mon_index_o,
  output wire [7:0] mon_wdata_o,
  output wire mon_wr_o,
  output wire mon_rd_o,
  input wire [7:0] mon_rdata_i,
  // Pins 4.5..4.7, bit 0 is 4.5
  input wire [2:0] pin_in_i,
  output wire [2:0] pin_out_o,
  output wire [2:0] pin_oe_o,
  // Alternate function sources and sinks
  input wire [2:0] pci_reset_out_n_i,
  input wire serial_six_output_n_i,
  output wire serial_six_receive_o,
  output wire serial_six_input_n_o,
  input wire drive_density_select_i,
  // SMI pin and system events
  input wire smi_group_i,
  output wire smi_output_pin_out_o,
  output wire smi_output_pin_oe_o,
  input wire main_por_i,
  input wire pin_5_3_is_input_i,
  // Interrupt
  output wire irq_o
);

  // Pin control registers
  reg [7:0] pin_ctl_r [0:NPIN-1];
  reg [7:0] mon_index_r; // Monitor index
  reg [7:0] irq_sts_r; // Sticky events
  reg [7:0] irq_mask_r; // Interrupt mask
  reg [7:0] misc_ctl_r; // Misc control
  reg [7:0] wake_sts5_r; // Stored only
  reg [7:0] wake_aux_r; // Stored only
  // Three-stage synchroniser for pins
  reg [2:0] sync1_r;
  reg [2:0] sync2_r;
  reg [2:0] sync3_r;
  reg [2:0] pin_state_r; // Accepted pin level
  reg [7:0] rdata_nxt;
  integer i;

  // Reset value of a pin control register per variant
  function [7:0] pin_rst;
    input six;
    begin
      pin_rst = six ? `RGC_RST_PIN_SIX : `RGC_RST_PIN_RST;
    end
  endfunction

  // Offset decode into a pin index, or 3 when not a pin register
  function [1:0] pin_idx;
    input [7:0] a;
    begin
      case (a)
        `RGC_OFF_PIN45: pin_idx = 2'd0;
        `RGC_OFF_PIN46: pin_idx = 2'd1;
        `RGC_OFF_PIN47: pin_idx = 2'd2;
        default: pin_idx = 2'd3;
      endcase
    end
  endfunction

  wire [1:0] wr_pin = pin_idx(reg_addr_i);
  wire edge_sel = misc_ctl_r[`RGC_BIT_EDGE_SEL];
  wire dens_sel = misc_ctl_r[`RGC_BIT_DENS_SEL];

  // Monitor access straight through, index held until rewritten
  assign mon_index_o = mon_index_r; // RULE_07 RULE_19
  assign mon_wdata_o = reg_wdata_i;
  assign mon_wr_o = reg_wr_i && (reg_addr_i == `RGC_OFF_MON_DATA); // RULE_08
  assign mon_rd_o = reg_rd_i && (reg_addr_i == `RGC_OFF_MON_DATA); // RULE_08

  // Pin synchroniser: change accepted when stage two and three agree
  always @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
      sync3_r <= 3'h0;
      pin_state_r <= 3'h0;
    end
    else
    begin
      sync1_r <= pin_in_i;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      // Bitwise agree filter
      pin_state_r <= (sync2_r & sync3_r) | (pin_state_r & (sync2_r | sync3_r));
    end
  end

  // Both edges on pin 4.5 count as an event when edge mode is on and pin 4.5 is an input
  wire [2:0] pin_next = (sync2_r & sync3_r) | (pin_state_r & (sync2_r | sync3_r));
  wire edge_evt = edge_sel && pin_ctl_r[0][`RGC_BIT_DIR]
    && (pin_next[0] != pin_state_r[0]); // RULE_11
  wire por_evt = main_por_i && pin_5_3_is_input_i; // RULE_15

  // Event vector into sticky status: bit0 edge, bit1 main POR
  wire [7:0] evt_vec = {6'h00, por_evt, edge_evt};

  // Register writes and event capture
  always @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      for (i = 0; i < NPIN; i = i + 1)
        pin_ctl_r[i] <= pin_rst(SIX_PORT != 0);
      mon_index_r <= `RGC_RST_ZERO; // RULE_07
      irq_sts_r <= `RGC_RST_ZERO;
      irq_mask_r <= `RGC_RST_ZERO;
      misc_ctl_r <= `RGC_RST_ZERO;
      wake_sts5_r <= `RGC_RST_ZERO;
      wake_aux_r <= `RGC_RST_ZERO;
    end
    else
    begin
      // Pin control, all eight bits stored, reserved bits inert
      if (reg_wr_i && wr_pin != 2'd3)
        pin_ctl_r[wr_pin] <= reg_wdata_i; // RULE_06
      if (reg_wr_i && reg_addr_i == `RGC_OFF_MON_INDEX)
        mon_index_r <= reg_wdata_i; // RULE_19
      if (reg_wr_i && reg_addr_i == `RGC_OFF_IRQ_MASK)
        irq_mask_r <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == `RGC_OFF_MISC_CTL)
        misc_ctl_r <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == `RGC_OFF_WAKE_AUX)
        wake_aux_r <= reg_wdata_i; // RULE_16
      // Wake status: writable, set on main POR; set wins over write
      if (reg_wr_i && reg_addr_i == `RGC_OFF_WAKE_STS5)
        wake_sts5_r <= reg_wdata_i; // RULE_16
      if (por_evt)
        wake_sts5_r[`RGC_BIT_WS5_P53] <= 1'b1; // RULE_15
      // Sticky status: write one clears, new event wins
      if (reg_wr_i && reg_addr_i == `RGC_OFF_IRQ_STS)
        irq_sts_r <= (irq_sts_r & ~reg_wdata_i) | evt_vec;
      else
        irq_sts_r <= irq_sts_r | evt_vec; // RULE_11
    end
  end

  assign irq_o = |(irq_sts_r & irq_mask_r);

  // Read mux, registered so data stand the cycle after the strobe
  always @*
  begin
    rdata_nxt = 8'h00;
    case (reg_addr_i)
      `RGC_OFF_PIN45: rdata_nxt = pin_ctl_r[0];
      `RGC_OFF_PIN46: rdata_nxt = pin_ctl_r[1];
      `RGC_OFF_PIN47: rdata_nxt = pin_ctl_r[2];
      `RGC_OFF_MON_INDEX: rdata_nxt = mon_index_r;
      // Monitor answers in the strobe cycle, captured like any register
      `RGC_OFF_MON_DATA: rdata_nxt = mon_rdata_i; // RULE_08
      `RGC_OFF_IRQ_STS: rdata_nxt = irq_sts_r;
      `RGC_OFF_IRQ_MASK: rdata_nxt = irq_mask_r;
      `RGC_OFF_MISC_CTL: rdata_nxt = misc_ctl_r;
      `RGC_OFF_PIN_STATE: rdata_nxt = {5'h00, pin_state_r};
      `RGC_OFF_WAKE_STS5: rdata_nxt = wake_sts5_r;
      `RGC_OFF_WAKE_AUX: rdata_nxt = wake_aux_r;
      // Reserved 74-7F and unmapped read zero
      default: rdata_nxt = 8'h00; // RULE_09
    endcase
  end

  // Read data register; monitor data comes back one cycle later too
  always @(posedge core_clk_i)
  begin
    if (srst_i)
      reg_rdata_o <= 8'h00;
    else if (reg_rd_i)
      reg_rdata_o <= rdata_nxt;
    else
      reg_rdata_o <= 8'h00;
  end
  // Monitor read data reaches the bus through the read mux above

  // Per-pin drive
  genvar g;
  generate
    for (g = 0; g < NPIN; g = g + 1)
    begin : pin_g
      wire [7:0] c = pin_ctl_r[g];
      wire alt = (SIX_PORT != 0) ? c[`RGC_BIT_ALT] : ~c[`RGC_BIT_ALT]; // RULE_03 RULE_04
      wire is_in = c[`RGC_BIT_DIR]; // RULE_01
      wire inv = c[`RGC_BIT_POL]; // RULE_02
      // Drive source: GPIO value is the inverted-or-not output; here low
      wire dens_here = dens_sel && (g == 0);
      wire src_val = dens_here ? drive_density_select_i
        : (alt ? ((SIX_PORT != 0) ? (g == 2 ? serial_six_output_n_i : 1'b1)
                                  : pci_reset_out_n_i[g])
               : 1'b0);
      wire val = src_val ^ inv; // RULE_02
      // Floppy bit overrides type when density function is on this pin
      wire od = dens_here ? misc_ctl_r[`RGC_BIT_FDD_OD]
        : c[`RGC_BIT_OTYPE]; // RULE_05 RULE_12
      wire drive = ~is_in || (dens_here && misc_ctl_r[`RGC_BIT_FDD_B7]); // RULE_12
      assign pin_out_o[g] = od ? 1'b0 : val;
      assign pin_oe_o[g] = drive && (od ? ~val : 1'b1); // RULE_05
    end
  endgenerate

  // Serial six inputs from the synchronised pins
  assign serial_six_receive_o = (SIX_PORT != 0) && pin_ctl_r[0][`RGC_BIT_ALT]
    ? pin_state_r[0] ^ pin_ctl_r[0][`RGC_BIT_POL] : 1'b1; // RULE_03
  assign serial_six_input_n_o = (SIX_PORT != 0) && pin_ctl_r[1][`RGC_BIT_ALT]
    ? pin_state_r[1] ^ pin_ctl_r[1][`RGC_BIT_POL] : 1'b1; // RULE_03

  // SMI pin: active low only when grouped SMI and enable both set
  wire smi_act = smi_group_i && misc_ctl_r[`RGC_BIT_SMI_EN]; // RULE_13
  assign smi_output_pin_out_o = ~smi_act; // RULE_14
  assign smi_output_pin_oe_o = smi_act || ~misc_ctl_r[`RGC_BIT_SMI_OD]; // RULE_14

endmodule

// ==== src/rgc_map.vh ====
// Purpose: Offsets, field positions and reset values for the runtime GPIO window
// Assumes: Byte-wide register port, offsets as printed
// Notes: Definitions only
`ifndef RGC_MAP_VH
`define RGC_MAP_VH
// Printed register offsets
`define RGC_OFF_PIN45 8'h6F
`define RGC_OFF_MON_INDEX 8'h70
`define RGC_OFF_MON_DATA 8'h71
`define RGC_OFF_PIN46 8'h72
`define RGC_OFF_PIN47 8'h73
`define RGC_OFF_RSV_LO 8'h74
`define RGC_OFF_RSV_HI 8'h7F
// Added control and status registers
`define RGC_OFF_IRQ_STS 8'h80
`define RGC_OFF_IRQ_MASK 8'h81
`define RGC_OFF_MISC_CTL 8'h82
`define RGC_OFF_PIN_STATE 8'h83
`define RGC_OFF_WAKE_STS5 8'h84
`define RGC_OFF_WAKE_AUX 8'h85
// Pin control fields
`define RGC_BIT_DIR 0
`define RGC_BIT_POL 1
`define RGC_BIT_ALT 2
`define RGC_BIT_OTYPE 7
// Misc control fields
`define RGC_BIT_SMI_EN 0
`define RGC_BIT_FDD_OD 1
`define RGC_BIT_FDD_B7 2
`define RGC_BIT_DENS_SEL 3
`define RGC_BIT_EDGE_SEL 4
`define RGC_BIT_SMI_OD 5
// Wake status fifth field
`define RGC_BIT_WS5_P53 3
// Reset values
`define RGC_RST_PIN_SIX 8'h01
`define RGC_RST_PIN_RST 8'h00
`define RGC_RST_ZERO 8'h00
`endif

// ==== verif/rgc_gpio_window_properties.sv ====
// Purpose: Port-level properties of the GPIO window
// Assumes: One clock, synchronous active-high reset
// Notes: Ports grouped a few to a line to save room
module rgc_chk (
  // Clock, reset, strobes
  input wire core_clk_i, srst_i, reg_wr_i, reg_rd_i,
  // Register and monitor buses
  input wire [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, mon_index_o, mon_wdata_o,
  // Monitor strobes, SMI pin, interrupt
  input wire mon_wr_o, mon_rd_o, smi_group_i, smi_output_pin_out_o, smi_output_pin_oe_o, irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  property p_rsv_zero; reg_rd_i && reg_addr_i inside {[8'h74:8'h7F]} |=> reg_rdata_o == 0; endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved read not zero");
  property p_idx_set; reg_wr_i && reg_addr_i == 8'h70 |=> mon_index_o == $past(reg_wdata_i); endproperty
  a_idx_set: assert property (p_idx_set) else $error("index not loaded");
  property p_idx_hold; !(reg_wr_i && reg_addr_i == 8'h70) |=> $stable(mon_index_o); endproperty
  a_idx_hold: assert property (p_idx_hold) else $error("index moved");
  property p_idx_rd; reg_rd_i && reg_addr_i == 8'h70 |=> reg_rdata_o == $past(mon_index_o); endproperty
  a_idx_rd: assert property (p_idx_rd) else $error("index readback wrong");
  property p_mon_wr; mon_wr_o == (reg_wr_i && reg_addr_i == 8'h71); endproperty
  a_mon_wr: assert property (p_mon_wr) else $error("monitor write strobe wrong");
  property p_mon_rd; mon_rd_o == (reg_rd_i && reg_addr_i == 8'h71); endproperty
  a_mon_rd: assert property (p_mon_rd) else $error("monitor read strobe wrong");
  property p_mon_wd; mon_wr_o |-> mon_wdata_o == reg_wdata_i; endproperty
  a_mon_wd: assert property (p_mon_wd) else $error("monitor data wrong");
  property p_smi_idle; !smi_group_i |-> !smi_output_pin_oe_o || smi_output_pin_out_o; endproperty
  a_smi_idle: assert property (p_smi_idle) else $error("SMI pin active");
  c_rsv: cover property (reg_rd_i && reg_addr_i == 8'h7F);
  c_mwr: cover property (mon_wr_o);
  c_irq: cover property ($rose(irq_o));
endmodule
bind rgc_gpio_window rgc_chk u_chk (.core_clk_i(core_clk_i), .srst_i(srst_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .mon_index_o(mon_index_o), .mon_wdata_o(mon_wdata_o),
  .mon_wr_o(mon_wr_o), .mon_rd_o(mon_rd_o), .smi_group_i(smi_group_i),
  .smi_output_pin_out_o(smi_output_pin_out_o), .smi_output_pin_oe_o(smi_output_pin_oe_o),
  .irq_o(irq_o));

// ==== verif/rgc_pin_world.sv ====
// Purpose: Board pins and monitor register file beside the window
// Assumes: Released pins follow the board level ext_i
// Notes: Monitor file is written only through the forwarded strobe
module rgc_pin_world (
  input wire core_clk_i,
  input wire [2:0] pin_out_i, pin_oe_i, ext_i,
  output wire [2:0] pin_in_o,
  input wire [7:0] mon_index_i, mon_wdata_i,
  input wire mon_wr_i,
  output wire [7:0] mon_rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:255];
  // Driven pins read their own level, released ones the board
  assign pin_in_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & ext_i);
  assign mon_rdata_o = mem[mon_index_i];
  initial foreach (mem[i]) mem[i] = 8'h00;
  // Store at the selected index
  always @(posedge core_clk_i) if (mon_wr_i) mem[mon_index_i] <= mon_wdata_i;
endmodule

// ==== verif/rgc_gpio_window_tb.sv ====
// Purpose: Register-level tests of the GPIO window
// Assumes: Reset variant, pins 4.6 and 4.7 left at default
// Notes: Strobes change by non-blocking assignment at the edge
module rgc_gpio_window_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, wr = 0, rd = 0, grp = 0, por = 0, p53 = 0, mwr, mrdo, smo, smoe, irq;
  logic [7:0] addr = 0, wd = 0, rdat, idx, mwd, mrd;
  logic [2:0] ext = 0, pin_in, pout, poe;
  logic [7:0] cfg [7] = '{8'h00, 8'h02, 8'h80, 8'h82, 8'h01, 8'h78, 8'h04};
  logic [7:0] pex [7] = '{8'h03, 8'h02, 8'h00, 8'h02, 8'h00, 8'h03, 8'h02};
  logic [7:0] rv [9] = '{8'h6F, 8'h70, 8'h71, 8'h72, 8'h73, 8'h80, 8'h81, 8'h82, 8'h84};
  logic [15:0] smt [5] = '{16'h0013, 16'h0112, 16'h2100, 16'h2112, 16'h0103};
  int mismatches = 0, cmp_count = 0;
  always #20 clk = ~clk;
  rgc_gpio_window DUT (.core_clk_i(clk), .srst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wd),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat), .mon_index_o(idx), .mon_wdata_o(mwd),
    .mon_wr_o(mwr), .mon_rd_o(mrdo), .mon_rdata_i(mrd), .pin_in_i(pin_in), .pin_out_o(pout),
    .pin_oe_o(poe), .pci_reset_out_n_i(3'b101), .serial_six_output_n_i(1'b1),
    .serial_six_receive_o(), .serial_six_input_n_o(), .drive_density_select_i(1'b0),
    .smi_group_i(grp), .smi_output_pin_out_o(smo), .smi_output_pin_oe_o(smoe),
    .main_por_i(por), .pin_5_3_is_input_i(p53), .irq_o(irq));
  rgc_pin_world u_mon (.core_clk_i(clk), .pin_out_i(pout), .pin_oe_i(poe), .ext_i(ext),
    .pin_in_o(pin_in), .mon_index_i(idx), .mon_wdata_i(mwd), .mon_wr_i(mwr), .mon_rdata_o(mrd));
  // Count every compare, report a miss at once
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    cmp_count++;
    if (s !== e)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  // One-cycle write; outputs settle before return
  task automatic wrr(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
    #1;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rdr(logic [7:0] a, logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1;
    chk($sformatf("reg %h", a), rdat, e);
  endtask
  task automatic final_report;
    $display("Compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Watchdog far beyond the expected run
  initial
  begin
    repeat (5000) @(posedge clk);
    mismatches++;
    final_report();
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 0;
    foreach (rv[i]) rdr(rv[i], 8'h00);
    chk("pins", {4'h0, pout[2:1], poe[2:1]}, 8'h0B);
    foreach (cfg[i])
    begin
      wrr(8'h6F, cfg[i]);
      chk("pin", {poe[0], poe[0] & pout[0]}, pex[i]);
    end
    wrr(8'h6F, 8'h05);
    wrr(8'h82, 8'h10);
    repeat (6) @(posedge clk);
    wrr(8'h80, 8'hFF);
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clk);
      ext[0] <= !k;
      repeat (6) @(posedge clk);
      rdr(8'h80, 8'h01);
      chk("irq", irq, 0);
      wrr(8'h81, 8'h01);
      chk("irq", irq, 1);
      wrr(8'h81, 8'h00);
      chk("irq", irq, 0);
      wrr(8'h80, 8'h01);
      rdr(8'h80, 8'h00);
    end
    @(posedge clk);
    por <= 1;
    p53 <= 1;
    repeat (2) @(posedge clk);
    por <= 0;
    repeat (2) @(posedge clk);
    rdr(8'h84, 8'h08);
    rdr(8'h80, 8'h02);
    wrr(8'h80, 8'h02);
    wrr(8'h84, 8'hA5);
    rdr(8'h84, 8'hA5);
    wrr(8'h85, 8'h01);
    rdr(8'h85, 8'h01);
    foreach (smt[i])
    begin
      @(posedge clk);
      grp <= smt[i][4];
      wrr(8'h82, smt[i][15:8]);
      chk("smi", {smoe, smoe & smo}, smt[i][1:0]);
    end
    wrr(8'h70, 8'h33);
    wrr(8'h71, 8'hC4);
    rdr(8'h70, 8'h33);
    rdr(8'h71, 8'hC4);
    chk("mon", u_mon.mem[8'h33], 8'hC4);
    for (int a = 8'h74; a <= 8'h90; a += (a == 8'h7F) ? 17 : 1)
    begin
      wrr(a[7:0], 8'hFF);
      rdr(a[7:0], 8'h00);
    end
    final_report();
  end
endmodule
